/* hw/sxp_defines.vh */
// Purpose: constants of the serial transfer port
// Assumes: included by bare name
// Notes:   byte address of a register is four times its index
`ifndef SXP_DEFINES_VH
`define SXP_DEFINES_VH
// Register indices and byte addresses
`define SXP_IDX_MAIN_CTRL   8'h10
`define SXP_IDX_FLAG_CTRL   8'h11
`define SXP_IDX_DATA_PORT   8'h12
`define SXP_ADDR_MAIN_CTRL  8'h40
`define SXP_ADDR_FLAG_CTRL  8'h44
`define SXP_ADDR_DATA_PORT  8'h48
// Main control fields
`define SXP_MC_RX_IE        7
`define SXP_MC_MASTER       5
`define SXP_MC_CLOCK_POLARITY_BIT         4
`define SXP_MC_PHASE_SELECT_BIT         3
`define SXP_MC_WOM          2
`define SXP_MC_ENABLE       1
`define SXP_MC_TX_IE        0
`define SXP_MC_RESET        8'h28
`define SXP_MC_WMASK        8'hBF
// Flag control fields
`define SXP_FC_RX_FULL      7
`define SXP_FC_ERR_IE       6
`define SXP_FC_OVR          5
`define SXP_FC_FAULT        4
`define SXP_FC_TX_EMPTY     3
`define SXP_FC_FAULT_EN     2
`define SXP_FC_RATE_HI      1
`define SXP_FC_RATE_LO      0
// Half bit times in bus cycles for the four rates
`define SXP_HALF_RATE0      7'h01
`define SXP_HALF_RATE1      7'h04
`define SXP_HALF_RATE2      7'h10
`define SXP_HALF_RATE3      7'h40
// Bits per transfer and the sample index of bit 1
`define SXP_BITS            4'h8
`define SXP_OVR_SAMPLE      4'h6
`define SXP_EDGES_LAST      4'hF
`endif

/* hw/sxp_rate_div.v */
// Purpose: free running half bit tick for the master shift clock
// Assumes: one bus clock, asynchronous active low reset
// Notes:   counter held at zero while not running
`timescale 1ns/1ps
`default_nettype none
`include "sxp_defines.vh"
module sxp_rate_div (
    // Clock and reset
    input  wire       clk_sys_i,
    input  wire       arst_n_i,
    // Control
    input  wire       run_i,
    input  wire [1:0] rate_i,
    // Tick
    output reg        tick_o
);
    reg  [6:0] cnt_ff;
    reg  [6:0] half;

    always @* begin
        case (rate_i)
            2'b00:   half = `SXP_HALF_RATE0;
            2'b01:   half = `SXP_HALF_RATE1;
            2'b10:   half = `SXP_HALF_RATE2;
            default: half = `SXP_HALF_RATE3;
        endcase
    end

    // Divide runs only while enabled as master
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_ff <= 7'h00;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_ff <= 7'h00;
            tick_o <= 1'b0;
        end else if (cnt_ff >= half - 7'h01) begin
            cnt_ff <= 7'h00;
            tick_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 7'h01;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* hw/sxp_serial_port.v */
// Purpose: master/slave synchronous serial port with APB registers
// Assumes: all pin inputs synchronous to clk_sys_i
// Notes:   zero wait APB; unmapped addresses answer with pslverr
`timescale 1ns/1ps
`default_nettype none
`include "sxp_defines.vh"
// Behaviour
// - Slave write during transfer waits in buffer
// - No new byte: resend shift register contents
// - Shift out and in together, one clock
// - Slave drives data out only while selected
// - Four phase/polarity modes; polarity sets idle level
// - Phase 0: present MSB, start at select fall
// - Phase 1: first clock edge starts transfer
// - Master data write starts transfer, phase-independent delay
// - Master clock idle first half in phase 0
// - Master shift clock runs only when enabled master
// - Start delay at most one bit time
// - Overrun at bit 1 capture, keep old byte
// - No receive-full while overrun pending
// - One enable gates both error flags
// - Receive, overrun, fault share one request
// - Fault flag sets only with fault enable
// - Fault flag reports select conflicting with mode
// - Master select low: fault, disable, clear state
// - Slave select high mid-transfer sets fault
// - Fault clears by flag read then control write
// - Receive full clears by flag read, data read
module sxp_serial_port #(
    parameter ADDR_W = 8
) (
    // Clock and reset
    input  wire              clk_sys_i,
    input  wire              arst_n_i,
    // APB slave
    input  wire              psel_i,
    input  wire              penable_i,
    input  wire              pwrite_i,
    input  wire [ADDR_W-1:0] paddr_i,
    input  wire [31:0]       pwdata_i,
    output reg  [31:0]       prdata_o,
    output reg               pready_o,
    output reg               pslverr_o,
    // Interrupt requests
    output reg               rx_err_irq_o,
    output reg               tx_irq_o,
    // Serial pins
    input  wire              shift_clock_pin_i,
    output reg               shift_clock_pin_o,
    output reg               shift_clock_pin_oe_o,
    input  wire              mosi_i,
    output reg               mosi_o,
    output reg               mosi_oe_o,
    input  wire              miso_i,
    output reg               miso_o,
    output reg               miso_oe_o,
    input  wire              select_low_pin_n_i
);
    reg  [7:0] ctrl_ff;
    reg        err_ie_ff;
    reg        fault_en_ff;
    reg  [1:0] rate_ff;
    reg        rx_full_ff;
    reg        ovr_ff;
    reg        fault_ff;
    reg        tx_empty_ff;
    reg  [7:0] tx_buf_ff;
    reg  [7:0] rx_buf_ff;
    reg  [7:0] shift_ff;
    reg        smp_ff;
    reg  [3:0] bit_cnt_ff;
    reg  [3:0] edge_cnt_ff;
    reg        busy_ff;
    reg        ovr_hit_ff;
    reg        sck_ff;
    reg        sck_in_ff;
    reg        sel_in_ff;
    reg        arm_rx_ff;
    reg        arm_ovr_ff;
    reg        arm_fault_ff;

    wire       unit_en     = ctrl_ff[`SXP_MC_ENABLE];
    wire       master      = ctrl_ff[`SXP_MC_MASTER];
    wire       clock_polarity_bit        = ctrl_ff[`SXP_MC_CLOCK_POLARITY_BIT];
    wire       phase_select_bit        = ctrl_ff[`SXP_MC_PHASE_SELECT_BIT];
    wire       tick;
    wire       setup_ph    = psel_i & ~penable_i;
    wire       access      = psel_i & penable_i & pready_o;
    wire       wr          = access & pwrite_i;
    wire       rd          = access & ~pwrite_i;
    wire       hit_main    = (paddr_i == `SXP_ADDR_MAIN_CTRL);
    wire       hit_flag    = (paddr_i == `SXP_ADDR_FLAG_CTRL);
    wire       hit_data    = (paddr_i == `SXP_ADDR_DATA_PORT);
    wire       wr_main     = wr & hit_main;
    wire       wr_flag     = wr & hit_flag;
    wire       wr_data     = wr & hit_data;
    wire       rd_flag     = rd & hit_flag;
    wire       rd_data     = rd & hit_data;
    wire [7:0] flag_rd     = {rx_full_ff, err_ie_ff, ovr_ff, fault_ff, tx_empty_ff, fault_en_ff, rate_ff};

    // Mode conflict on the select pin
    wire       m_fault     = unit_en & master & fault_en_ff & ~select_low_pin_n_i;
    wire       s_fault     = unit_en & ~master & fault_en_ff & busy_ff & select_low_pin_n_i;
    wire       fault_cond  = m_fault | s_fault;

    // Slave clock edges, ignored while not selected
    wire       s_sel       = unit_en & ~master & ~select_low_pin_n_i;
    wire       s_lead      = s_sel & (sck_in_ff == clock_polarity_bit) & (shift_clock_pin_i != clock_polarity_bit);
    wire       s_trail     = s_sel & (sck_in_ff != clock_polarity_bit) & (shift_clock_pin_i == clock_polarity_bit);
    wire       s_start0    = s_sel & ~phase_select_bit & sel_in_ff & ~busy_ff;
    wire       s_start1    = s_lead & phase_select_bit & ~busy_ff;

    // Master edges come from the half bit tick
    wire       m_start     = unit_en & master & tick & ~busy_ff & ~tx_empty_ff;
    wire       m_edge      = unit_en & master & tick & busy_ff;
    wire       lead        = master ? (m_edge & ~edge_cnt_ff[0]) : (s_lead & busy_ff);
    wire       trail       = master ? (m_edge & edge_cnt_ff[0]) : (s_trail & busy_ff);
    wire       start       = m_start | s_start0 | s_start1;
    wire       din         = master ? miso_i : mosi_i;

    // Sample and shift edges by phase
    wire       samp_ev     = phase_select_bit ? trail : lead;
    wire       shift_ev    = phase_select_bit ? (lead & (bit_cnt_ff != 4'h0)) : trail;
    wire       done0       = ~phase_select_bit & trail & (bit_cnt_ff == `SXP_BITS);
    wire       done1       = phase_select_bit & trail & (bit_cnt_ff == `SXP_BITS - 4'h1);
    wire       done        = done0 | done1;
    wire [7:0] done_byte   = done1 ? {shift_ff[6:0], din} : {shift_ff[6:0], smp_ff};
    wire       ovr_now     = samp_ev & (bit_cnt_ff == `SXP_OVR_SAMPLE) & rx_full_ff;

    // Pin look-ahead: pin edges line up with the engine's own edges, so the
    // far side's answer to one edge has settled before the next sample
    wire       halt        = ~unit_en | m_fault | s_fault;
    wire       nxt_sck     = (halt | start) ? clock_polarity_bit :
                             (m_edge ? ~sck_ff : sck_ff);
    wire       nxt_msb     = halt ? shift_ff[7] :
                             start ? (tx_empty_ff ? shift_ff[7] : tx_buf_ff[7]) :
                             (shift_ev & ~done) ? shift_ff[6] :
                             shift_ff[7];

    sxp_rate_div u_rate_div (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .run_i     (unit_en & master),
        .rate_i    (rate_ff),
        .tick_o    (tick)
    );

    // APB answer: data and status registered in the setup cycle
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup_ph;
            pslverr_o <= setup_ph & ~(hit_main | hit_flag | hit_data);
            if (!setup_ph || pwrite_i) begin
                prdata_o <= 32'h0000_0000;
            end else if (hit_main) begin
                prdata_o <= {24'h00_0000, ctrl_ff & `SXP_MC_WMASK};
            end else if (hit_flag) begin
                prdata_o <= {24'h00_0000, flag_rd};
            end else if (hit_data) begin
                prdata_o <= {24'h00_0000, rx_buf_ff};
            end else begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    // Control registers; a master fault drops the enable
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_ff     <= `SXP_MC_RESET;
            err_ie_ff   <= 1'b0;
            fault_en_ff <= 1'b0;
            rate_ff     <= 2'b00;
        end else begin
            if (wr_main) begin
                ctrl_ff <= pwdata_i[7:0] & `SXP_MC_WMASK;
            end
            if (wr_flag) begin
                err_ie_ff   <= pwdata_i[`SXP_FC_ERR_IE];
                fault_en_ff <= pwdata_i[`SXP_FC_FAULT_EN];
                rate_ff     <= pwdata_i[1:0];
            end
            if (m_fault) begin
                ctrl_ff[`SXP_MC_ENABLE] <= 1'b0;
            end
        end
    end

    // Clear sequences: flag read arms, data read or control write clears
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            arm_rx_ff    <= 1'b0;
            arm_ovr_ff   <= 1'b0;
            arm_fault_ff <= 1'b0;
            rx_full_ff   <= 1'b0;
            ovr_ff       <= 1'b0;
            fault_ff     <= 1'b0;
        end else begin
            if (rd_flag) begin
                arm_rx_ff    <= rx_full_ff;
                arm_ovr_ff   <= ovr_ff;
                arm_fault_ff <= fault_ff & ~fault_cond;
            end else begin
                if (rd_data) begin
                    arm_rx_ff  <= 1'b0;
                    arm_ovr_ff <= 1'b0;
                end
                if (wr_main || fault_cond) begin
                    arm_fault_ff <= 1'b0;
                end
            end
            if (rd_data && arm_rx_ff && !rd_flag) begin
                rx_full_ff <= 1'b0;
            end
            if (rd_data && arm_ovr_ff && !rd_flag) begin
                ovr_ff <= 1'b0;
            end
            if (wr_main && arm_fault_ff && !fault_cond) begin
                fault_ff <= 1'b0;
            end
            // Hardware sets win over same-cycle clears
            if (ovr_now) begin
                ovr_ff <= 1'b1;
            end
            if (done && !ovr_hit_ff && !ovr_now && !ovr_ff) begin
                rx_full_ff <= 1'b1;
            end
            if (fault_cond) begin
                fault_ff <= 1'b1;
            end
        end
    end

    // Transmit buffer and transfer engine
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_buf_ff   <= 8'h00;
            tx_empty_ff <= 1'b1;
            rx_buf_ff   <= 8'h00;
            shift_ff    <= 8'h00;
            smp_ff      <= 1'b0;
            bit_cnt_ff  <= 4'h0;
            edge_cnt_ff <= 4'h0;
            busy_ff     <= 1'b0;
            ovr_hit_ff  <= 1'b0;
            sck_ff      <= 1'b0;
        end else if (!unit_en || m_fault || s_fault) begin
            // Disable or fault: abort and clear the state counter
            tx_empty_ff <= 1'b1;
            busy_ff     <= 1'b0;
            bit_cnt_ff  <= 4'h0;
            edge_cnt_ff <= 4'h0;
            ovr_hit_ff  <= 1'b0;
            sck_ff      <= clock_polarity_bit;
            if (!unit_en) begin
                shift_ff <= 8'h00;
            end
            if (wr_data) begin
                tx_buf_ff <= pwdata_i[7:0];
            end
        end else begin
            if (wr_data) begin
                tx_buf_ff   <= pwdata_i[7:0];
                tx_empty_ff <= 1'b0;
            end
            if (start) begin
                busy_ff     <= 1'b1;
                bit_cnt_ff  <= 4'h0;
                edge_cnt_ff <= 4'h0;
                ovr_hit_ff  <= 1'b0;
                sck_ff      <= clock_polarity_bit;
                if (!tx_empty_ff) begin
                    shift_ff    <= tx_buf_ff;
                    tx_empty_ff <= wr_data ? 1'b0 : 1'b1;
                end
            end else begin
                if (m_edge) begin
                    sck_ff      <= ~sck_ff;
                    edge_cnt_ff <= edge_cnt_ff + 4'h1;
                end
                if (samp_ev) begin
                    smp_ff     <= din;
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end
                if (ovr_now) begin
                    ovr_hit_ff <= 1'b1;
                end
                if (done) begin
                    busy_ff  <= 1'b0;
                    shift_ff <= done_byte;
                    if (!ovr_hit_ff && !ovr_now && !ovr_ff && !rx_full_ff) begin
                        rx_buf_ff <= done_byte;
                    end
                end else if (shift_ev) begin
                    shift_ff <= {shift_ff[6:0], smp_ff};
                end
            end
        end
    end

    // Pin sampling and registered pin drive
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_in_ff            <= 1'b0;
            sel_in_ff            <= 1'b1;
            shift_clock_pin_o    <= 1'b0;
            shift_clock_pin_oe_o <= 1'b0;
            mosi_o               <= 1'b0;
            mosi_oe_o            <= 1'b0;
            miso_o               <= 1'b0;
            miso_oe_o            <= 1'b0;
        end else begin
            sck_in_ff            <= shift_clock_pin_i;
            sel_in_ff            <= select_low_pin_n_i;
            shift_clock_pin_o    <= (unit_en & master) ? nxt_sck : clock_polarity_bit;
            shift_clock_pin_oe_o <= unit_en & master & ~m_fault;
            mosi_o               <= nxt_msb;
            mosi_oe_o            <= unit_en & master & ~m_fault;
            miso_o               <= nxt_msb;
            miso_oe_o            <= unit_en & ~master & ~select_low_pin_n_i;
        end
    end

    // One shared receive/error request
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_err_irq_o <= 1'b0;
            tx_irq_o     <= 1'b0;
        end else begin
            rx_err_irq_o <= (ctrl_ff[`SXP_MC_RX_IE] & unit_en & rx_full_ff & ~ovr_ff)
                          | (err_ie_ff & (ovr_ff | fault_ff));
            tx_irq_o     <= ctrl_ff[`SXP_MC_TX_IE] & tx_empty_ff;
        end
    end
endmodule
`default_nettype wire

/* sim/sxp_slave_model.sv */
// Purpose: external slave peripheral on the serial pins
// Assumes: select toggles around every byte
// Notes:   a released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module sxp_slave_model (
    // Pins
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       sel_n_i,
    // Mode and data
    input  wire logic       clock_polarity_bit_i,
    input  wire logic       phase_select_bit_i,
    input  wire logic [7:0] tx_i,
    output logic            miso_o,
    output logic [7:0]      rx_o,
    output logic            done_o
);
    logic [7:0] sh    = 8'h00;
    logic [3:0] ns    = 4'h0;
    logic       first = 1'b1;
    logic       last  = 1'b0;
    assign miso_o = sel_n_i ? ~last : sh[7];
    assign done_o = (ns == 4'h8);
    always @(negedge sel_n_i) begin
        sh = tx_i;
        ns = 4'h0;
        first = 1'b1;
    end
    always @(posedge sel_n_i) begin
        last = sh[7];
    end
    // Sample on one edge, shift on the other; phase 1 skips the first shift
    always @(sck_i) begin
        if (!sel_n_i) begin
            if ((sck_i != clock_polarity_bit_i) ^ phase_select_bit_i) begin
                rx_o = {rx_o[6:0], mosi_i};
                ns = ns + 4'h1;
            end else if (!(phase_select_bit_i && first)) begin
                sh = {sh[6:0], 1'b0};
            end
            first = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* sim/sxp_serial_port_assertions.sv */
// Purpose: port level checks of the serial transfer port
// Assumes: bound to the design's top module
// Notes:   sees ports only
`timescale 1ns/1ps
`default_nettype none
module sxp_serial_port_chk (
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        arst_n_i,
    // Bus
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Pins
    input wire logic        shift_clock_pin_oe_o,
    input wire logic        mosi_oe_o,
    input wire logic        miso_oe_o,
    input wire logic        select_low_pin_n_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    a_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_cause: assert property (pready_o |-> $past(psel_i && !penable_i))
        else $error("ready without setup");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside access");
    a_rdata_byte: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_miso_release: assert property (select_low_pin_n_i |=> !miso_oe_o)
        else $error("data out driven while deselected");
    a_one_driver: assert property (!(miso_oe_o && shift_clock_pin_oe_o))
        else $error("slave and master drive together");
    a_oe_pair: assert property (mosi_oe_o == shift_clock_pin_oe_o)
        else $error("master enables disagree");
    c_slave_drive: cover property (miso_oe_o);
    c_master_drive: cover property (shift_clock_pin_oe_o);
    c_bus_error: cover property (pslverr_o);
endmodule
bind sxp_serial_port sxp_serial_port_chk u_chk (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .shift_clock_pin_oe_o(shift_clock_pin_oe_o), .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o),
    .select_low_pin_n_i(select_low_pin_n_i)
);
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: self-checking bench of the serial transfer port
// Assumes: design, checker and slave model compiled first
// Notes:   pin levels resolved from the output enables
`timescale 1ns/1ps
`default_nettype none
`include "sxp_defines.vh"
`define SXP_CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
    localparam logic [7:0] AM = `SXP_ADDR_MAIN_CTRL;
    localparam logic [7:0] AF = `SXP_ADDR_FLAG_CTRL;
    localparam logic [7:0] AD = `SXP_ADDR_DATA_PORT;
    logic        clk_sys_i = 1'b0;
    logic        arst_n_i  = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0;
    logic        sck_m     = 1'b0;
    logic        mosi_m    = 1'b0;
    logic        sel_n     = 1'b1;
    logic        p_sel_n   = 1'b1;
    logic [7:0]  p_tx      = 8'h00;
    logic        clock_polarity_bit_v    = 1'b0;
    logic        phase_select_bit_v    = 1'b0;
    logic [31:0] seed      = 32'hC3F7;
    logic [31:0] dq;
    logic        de;
    int          hb        = 1;
    int          mismatches = 0;
    int          cmp_count = 0;
    wire  [31:0] prdata_o;
    wire         pready_o, pslverr_o, rx_err_irq_o, tx_irq_o;
    wire         shift_clock_pin_o, shift_clock_pin_oe_o, mosi_o, mosi_oe_o;
    wire         miso_o, miso_oe_o, p_miso, p_done;
    wire  [7:0]  p_rx;
    wire         sck_w  = shift_clock_pin_oe_o ? shift_clock_pin_o : sck_m;
    wire         mosi_w = mosi_oe_o ? mosi_o : mosi_m;
    wire         miso_w = miso_oe_o ? miso_o : p_miso;
    sxp_serial_port dut (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_err_irq_o(rx_err_irq_o), .tx_irq_o(tx_irq_o),
        .shift_clock_pin_i(sck_w), .shift_clock_pin_o(shift_clock_pin_o),
        .shift_clock_pin_oe_o(shift_clock_pin_oe_o), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
        .select_low_pin_n_i(sel_n)
    );
    sxp_slave_model u_far (
        .sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(p_sel_n), .clock_polarity_bit_i(clock_polarity_bit_v), .phase_select_bit_i(phase_select_bit_v),
        .tx_i(p_tx), .miso_o(p_miso), .rx_o(p_rx), .done_o(p_done)
    );
    always #50 clk_sys_i = ~clk_sys_i;
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 40);
        if (n >= 40)
            mismatches++;
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, dq, de);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
        logic [31:0] q;
        logic        er;
        apb(1'b0, a, 8'h00, q, er);
        `SXP_CHK(n, e, q[7:0] & m)
    endtask
    task automatic rxc(input logic [7:0] e);
        apb(1'b0, AF, 8'h00, dq, de);
        rdx(AD, 8'hFF, e, "rx byte");
    endtask
    // One master byte with the far slave selected around it
    task automatic mx(input logic [7:0] t, input logic [7:0] p);
        int n;
        p_tx <= p;
        p_sel_n <= 1'b0;
        @(posedge clk_sys_i);
        wr(AD, t);
        n = 0;
        while (sck_w === clock_polarity_bit_v && n < 400) begin
            @(posedge clk_sys_i);
            n++;
        end
        `SXP_CHK("start delay", 1'b1, n <= 2 * hb + 3)
        n = 0;
        while (p_done !== 1'b1 && n < 3000) begin
            @(posedge clk_sys_i);
            n++;
        end
        repeat (hb + 3) @(posedge clk_sys_i);
        `SXP_CHK("far rx", t, p_rx)
        `SXP_CHK("clock idle", clock_polarity_bit_v, sck_w)
        p_sel_n <= 1'b1;
        @(posedge clk_sys_i);
    endtask
    // Bench acts as master towards the design in slave mode, half period four cycles, idle half eight in phase 0
    task automatic sx(input logic [7:0] m, output logic [7:0] g);
        sel_n <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        for (int i = 7; i >= 0; i--) begin
            if (phase_select_bit_v)
                sck_m <= ~clock_polarity_bit_v;
            mosi_m <= m[i];
            repeat (4) @(posedge clk_sys_i);
            g[i] = miso_w;
            sck_m <= phase_select_bit_v ? clock_polarity_bit_v : ~clock_polarity_bit_v;
            repeat (4) @(posedge clk_sys_i);
            if (!phase_select_bit_v)
                sck_m <= clock_polarity_bit_v;
            if (!phase_select_bit_v)
                repeat (4) @(posedge clk_sys_i);
        end
        if (!phase_select_bit_v)
            sel_n <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
    endtask
    initial begin
        #3000000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        logic [7:0] t, p, u, g;
        repeat (10) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rdx(AM, 8'hFF, `SXP_MC_RESET, "main reset");
        rdx(AF, 8'hFF, 8'h08, "flag reset");
        apb(1'b0, 8'h4C, 8'h00, dq, de);
        `SXP_CHK("unmapped", 1'b1, de)
        for (int c = 0; c < 4; c++) begin
            clock_polarity_bit_v <= c[1];
            phase_select_bit_v <= c[0];
            sck_m <= c[1];
            hb = 1 << (2 * c);
            wr(AM, {2'b00, 1'b1, c[1], c[0], 3'b000});
            wr(AF, {6'h00, c[1:0]});
            wr(AM, {2'b00, 1'b1, c[1], c[0], 3'b010});
            t = rnd();
            p = rnd();
            mx(t, p);
            rdx(AF, 8'h80, 8'h80, "rx full");
            rdx(AD, 8'hFF, p, "master rx");
            rdx(AF, 8'h80, 8'h00, "rx cleared");
            wr(AM, {3'b000, c[1], c[0], 3'b000});
            wr(AM, {3'b000, c[1], c[0], 3'b010});
            t = rnd();
            p = rnd();
            u = rnd();
            wr(AD, t);
            sx(p, g);
            `SXP_CHK("slave tx", t, g)
            rxc(p);
            fork
                sx(u, g);
                begin
                    repeat (20) @(posedge clk_sys_i);
                    wr(AD, t ^ 8'hA5);
                end
            join
            `SXP_CHK("slave resend", p, g)
            rxc(u);
            sx(p, g);
            `SXP_CHK("slave queued", t ^ 8'hA5, g)
            rxc(p);
            sel_n <= 1'b1;
        end
        hb = 4;
        wr(AF, 8'h41);
        wr(AM, 8'h3A);
        t = rnd();
        p = rnd();
        mx(t, p);
        mx(rnd(), rnd());
        rdx(AF, 8'hA0, 8'hA0, "overrun set");
        `SXP_CHK("err irq", 1'b1, rx_err_irq_o)
        rxc(p);
        rdx(AF, 8'hA0, 8'h00, "overrun clear");
        wr(AF, 8'h44);
        sel_n <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        `SXP_CHK("fault oe", 1'b0, shift_clock_pin_oe_o)
        `SXP_CHK("fault irq", 1'b1, rx_err_irq_o)
        rdx(AM, 8'h02, 8'h00, "fault unit off");
        wr(AM, 8'h38);
        rdx(AF, 8'h10, 8'h10, "fault needs read");
        rdx(AF, 8'h18, 8'h18, "fault flags");
        wr(AF, 8'h40);
        rdx(AF, 8'h10, 8'h10, "fault kept");
        sel_n <= 1'b1;
        @(posedge clk_sys_i);
        apb(1'b0, AF, 8'h00, dq, de);
        wr(AM, 8'h3A);
        rdx(AF, 8'h10, 8'h00, "fault cleared");
        `SXP_CHK("irq drop", 1'b0, rx_err_irq_o)
        sel_n <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rdx(AF, 8'h10, 8'h00, "fault blocked");
        `SXP_CHK("master still on", 1'b1, shift_clock_pin_oe_o)
        sel_n <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        wr(AM, 8'h3B);
        @(posedge clk_sys_i);
        `SXP_CHK("tx irq", 1'b1, tx_irq_o)
        report_and_stop();
    end
endmodule
`default_nettype wire
